// ---- rtl/mrc_regs.sv ----
// Purpose: Generic memory-mapped register slice for one peripheral unit
// Assumes: Plain strobe bus on ref_clk; event inputs come from same-clock logic
// Notes:   Defaults load at configuration time, and again on reset when RESET_DEFAULTS is set
//
// Summary of operation
// - Register address is region base plus map base plus index times stride plus offset.
// - Writes to read-only registers change nothing unless a write-only shares it.
// - Reads of write-only registers give no meaningful data.
// - Read/write registers are real storage returning the last value written.
// - No per-field mixed access registers; only RO, WO and RW exist.
// - Write-one-to-clear sticky bits hold until a one is written there.
// - Reset-cleared sticky bits hold until hard or soft reset; writes ignored.
// - Soft reset restores defaults only when the defaults option says so.
// - Unmarked RW bits stay uninitialised; unmarked RO bits show live state.
// - Status read and clear write share one address for W1C bits.
// - Every register spans at most 32 bits.
// - Defaults load at configuration, or on hard/soft reset if optioned.
// - Registers without defaults are never initialised.
// - Interrupt mask defaults to all sources masked; here imask_q loads all zeros.
// - Peripheral enable bits default to zero.
// - Register space is linear; no indirect or paged access.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module mrc_regs
  import mrc_pkg::*;
#(
  parameter logic [31:0] MMR_BASE       = 32'h0008_0000,
  parameter logic [31:0] MAP_BASE       = 32'h0000_0100,
  parameter logic [31:0] INDEX_STRIDE   = 32'h0000_0040,
  parameter int unsigned UNIT_INDEX     = 0,
  parameter int unsigned N_EVT          = 8,
  parameter bit          RESET_DEFAULTS = 1'b0,
  parameter logic [31:0] REV_VALUE      = REV_DEF
)(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [31:0]       bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic [DATA_W-1:0] live_status,
  input  wire logic [N_EVT-1:0]  evt_w1c,
  input  wire logic [N_EVT-1:0]  evt_rst,
  output logic      [CTRL_W-1:0] periph_en,
  output logic      [N_EVT-1:0]  irq_mask,
  output logic      [CMD_W-1:0]  cmd_pulse,
  output logic                   soft_reset
);
  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (N_EVT < 1 || N_EVT > MAX_SPAN_W) begin : g_chk_evt
    $error("N_EVT must lie between 1 and 32");
  end
  if (INDEX_STRIDE < SCR_BYTES + OFF_SCR) begin : g_chk_stride
    $error("INDEX_STRIDE too small for the register map");
  end

  // ****************************************************************
  // Address composition
  // ****************************************************************
  localparam logic [31:0] UNIT_BASE =
    32'(MMR_BASE + MAP_BASE + 32'(UNIT_INDEX) * INDEX_STRIDE);

  // Linear compare only; no paging window exists
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    return a == UNIT_BASE + off;
  endfunction : hit

  function automatic logic hit_scr(input logic [31:0] a);
    return (a >= UNIT_BASE + OFF_SCR) && (a < UNIT_BASE + OFF_SCR + SCR_BYTES)
           && (a[WORD_SHIFT-1:0] == '0);
  endfunction : hit_scr

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic h_rev, h_ctrl, h_imask, h_live, h_w1c, h_rst, h_cmd, h_scr, h_any;
  logic [31:0] scr_off;

  always_comb begin
    h_rev   = hit(bus_addr, OFF_REV);
    h_ctrl  = hit(bus_addr, OFF_CTRL);
    h_imask = hit(bus_addr, OFF_IMASK);
    h_live  = hit(bus_addr, OFF_LIVE);
    h_w1c   = hit(bus_addr, OFF_STK_W1C);
    h_rst   = hit(bus_addr, OFF_STK_RST);
    h_cmd   = hit(bus_addr, OFF_CMD);
    h_scr   = hit_scr(bus_addr);
    h_any   = h_rev | h_ctrl | h_imask | h_live | h_w1c | h_rst | h_cmd | h_scr;
    scr_off = bus_addr - UNIT_BASE - OFF_SCR;
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Configuration-time values; only loaded again on reset when optioned
  logic [CTRL_W-1:0] ctrl_q  = CTRL_DEF;
  logic [N_EVT-1:0]  imask_q = '0;
  logic [CTRL_W-1:0] ctrl_d;
  logic [N_EVT-1:0]  imask_d;
  logic [N_EVT-1:0]  w1c_q, w1c_d, clr_vec;
  logic [N_EVT-1:0]  stk_q, stk_d;
  logic [CMD_W-1:0]  cmd_q, cmd_d;
  logic              soft_q, soft_d, load_def;

  always_comb begin
    // Defaults only return by reset when the option is built in
    load_def = RESET_DEFAULTS && (!rstn || soft_q);
    ctrl_d   = ctrl_q;
    imask_d  = imask_q;
    if (load_def) begin
      ctrl_d  = CTRL_DEF;
      imask_d = '0;
    end else if (bus_wr && h_ctrl) begin
      ctrl_d  = bus_wdata[CTRL_W-1:0];
    end else if (bus_wr && h_imask) begin
      imask_d = bus_wdata[N_EVT-1:0];
    end
  end

  always_comb begin
    clr_vec = (bus_wr && h_w1c) ? bus_wdata[N_EVT-1:0] : '0;
    // New events win over a clear landing in the same cycle
    w1c_d   = (w1c_q & ~clr_vec) | evt_w1c;
    // Writes to this address never reach these; hard reset or soft reset clears them
    stk_d   = stk_q | evt_rst;
    if (soft_q) begin
      stk_d = evt_rst;
    end
    cmd_d   = (bus_wr && h_cmd) ? bus_wdata[CMD_W-1:0] : '0;
    soft_d  = bus_wr && h_cmd && bus_wdata[CMD_SOFT_B];
  end

  always_ff @(posedge ref_clk) begin
    ctrl_q  <= ctrl_d;
    imask_q <= imask_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      w1c_q  <= '0;
      stk_q  <= '0;
      cmd_q  <= '0;
      soft_q <= 1'b0;
    end else begin
      w1c_q  <= w1c_d;
      stk_q  <= stk_d;
      cmd_q  <= cmd_d;
      soft_q <= soft_d;
    end
  end

  // ****************************************************************
  // Scratch storage
  // ****************************************************************
  // Uninitialised words: a reset would cost area for no defined value
  mrc_store_if sif ();

  assign sif.wr_en = bus_wr && h_scr;
  assign sif.rd_en = bus_rd && h_scr;
  assign sif.addr  = scr_off[WORD_SHIFT+SCR_AW-1:WORD_SHIFT];
  assign sif.wdata = bus_wdata;

  mrc_store u_store (
    .ref_clk (ref_clk),
    .sif     (sif)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              scr_sel_q, scr_sel_d;

  always_comb begin
    rdata_d   = RD_ZERO;
    scr_sel_d = bus_rd && h_scr;
    // All registers are whole RO, WO or RW words; reserved bits read zero
    if (bus_rd) begin
      if (h_rev) begin
        rdata_d = REV_VALUE;
      end else if (h_ctrl) begin
        rdata_d[CTRL_W-1:0] = ctrl_q;
      end else if (h_imask) begin
        rdata_d[N_EVT-1:0] = imask_q;
      end else if (h_live) begin
        rdata_d = live_status;
      end else if (h_w1c) begin
        rdata_d[N_EVT-1:0] = w1c_q;
      end else if (h_rst) begin
        rdata_d[N_EVT-1:0] = stk_q;
      end else if (h_cmd) begin
        rdata_d = RD_ZERO;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_q   <= '0;
      scr_sel_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      scr_sel_q <= scr_sel_d;
    end
  end

  assign bus_rdata  = scr_sel_q ? sif.rdata : rdata_q;
  assign periph_en  = ctrl_q;
  assign irq_mask   = imask_q;
  assign cmd_pulse  = cmd_q;
  assign soft_reset = soft_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_w1c_one_clears: assert property (
    (bus_wr && h_w1c) |=>
      ((w1c_q & $past(bus_wdata[N_EVT-1:0]) & ~$past(evt_w1c)) == '0))
    else $error("W1C bit not cleared by written one");

  a_w1c_holds: assert property (
    1'b1 |=> (($past(w1c_q) & ~$past(clr_vec) & ~w1c_q) == '0))
    else $error("W1C bit dropped without a clear");

  a_w1c_event_sets: assert property (
    (evt_w1c != '0) |=> ((w1c_q & $past(evt_w1c)) == $past(evt_w1c)))
    else $error("W1C event lost");

  a_rst_sticky_holds: assert property (
    !soft_q |=> (($past(stk_q) & ~stk_q) == '0))
    else $error("Reset sticky bit cleared without reset");

  a_rw_readback: assert property (
    (bus_wr && h_ctrl && !load_def) ##1 (bus_rd && h_ctrl && !bus_wr && !load_def)
      |=> (bus_rdata == {{(DATA_W-CTRL_W){1'b0}}, $past(bus_wdata[CTRL_W-1:0], 2)}))
    else $error("Control readback mismatch");

  a_ro_write_ignored: assert property (
    (bus_wr && (h_rev || h_live || h_rst) && !load_def) |=>
      ($stable(ctrl_q) && $stable(imask_q)))
    else $error("Write to read-only register changed state");

  a_unmapped_reads_zero: assert property (
    (bus_rd && !h_any) |=> (bus_rdata == RD_ZERO))
    else $error("Unmapped read returned data");

  a_live_one_cycle: assert property (
    (bus_rd && h_live) |=> (bus_rdata == $past(live_status)))
    else $error("Live status not returned next cycle");

  a_defaults_on_reset: assert property (
    $rose(rstn) |-> (!RESET_DEFAULTS || (imask_q == '0 && ctrl_q == CTRL_DEF)))
    else $error("Defaults not loaded by hard reset");

  a_soft_defaults: assert property (
    (soft_q && RESET_DEFAULTS) |=> (imask_q == '0 && ctrl_q == CTRL_DEF))
    else $error("Defaults not loaded by soft reset");

  a_ctrl_write_lands: assert property (
    (bus_wr && h_ctrl && !load_def) |=>
      (periph_en == $past(bus_wdata[CTRL_W-1:0])))
    else $error("Control write did not land");

  a_rst_event_sets: assert property (
    (evt_rst != '0) |=> ((stk_q & $past(evt_rst)) == $past(evt_rst)))
    else $error("Reset sticky event lost");

  a_hard_reset_clears: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !rstn |=> (stk_q == '0 && w1c_q == '0 && cmd_q == '0 && !soft_q))
    else $error("Hard reset left sticky or pulse state");

  a_defaults_in_reset: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    (!rstn && RESET_DEFAULTS) |=> (imask_q == '0 && ctrl_q == CTRL_DEF))
    else $error("Defaults not loaded while in reset");

  a_cmd_pulse_value: assert property (
    (bus_wr && h_cmd) |=> (cmd_pulse == $past(bus_wdata[CMD_W-1:0])))
    else $error("Command pulse does not carry written value");

  a_cmd_pulse_idle: assert property (
    !(bus_wr && h_cmd) |=> (cmd_pulse == '0 && !soft_reset))
    else $error("Command pulse without a command write");

  a_soft_pulse: assert property (
    (bus_wr && h_cmd && bus_wdata[CMD_SOFT_B]) |=> soft_reset)
    else $error("Soft reset pulse missing");

  c_w1c_clear:   cover property ((w1c_q != '0) ##1 (bus_wr && h_w1c) ##1 (w1c_q == '0));
  c_soft_reset:  cover property (bus_wr && h_cmd && bus_wdata[CMD_SOFT_B] ##2 !soft_q);
  c_scr_readback: cover property ((bus_wr && h_scr) ##1 (bus_rd && h_scr));
  c_back_to_back: cover property ((bus_wr && h_ctrl) ##1 (bus_rd && h_ctrl));
  c_hard_reset:  cover property (@(posedge ref_clk) disable iff (1'b0) rstn ##1 !rstn);
endmodule : mrc_regs

// ---- rtl/mrc_pkg.sv ----
// Purpose: Shared constants for the memory-mapped register slice
// Assumes: 32-bit register bus, byte addresses, one aligned word per register
// Notes:   Offsets are relative to the composed base of one unit instance
package mrc_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned MAX_SPAN_W  = 32;
  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned CMD_W       = 8;
  localparam int unsigned SCR_DEPTH   = 4;
  localparam int unsigned SCR_AW      = 2;
  localparam int unsigned WORD_SHIFT  = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [31:0] OFF_REV     = 32'h0000_0000;
  localparam logic [31:0] OFF_CTRL    = 32'h0000_0004;
  localparam logic [31:0] OFF_IMASK   = 32'h0000_0008;
  localparam logic [31:0] OFF_LIVE    = 32'h0000_000C;
  localparam logic [31:0] OFF_STK_W1C = 32'h0000_0010;
  localparam logic [31:0] OFF_STK_RST = 32'h0000_0014;
  localparam logic [31:0] OFF_CMD     = 32'h0000_0018;
  localparam logic [31:0] OFF_SCR     = 32'h0000_0020;
  localparam logic [31:0] SCR_BYTES   = 32'h0000_0010;

  // ****************************************************************
  // Defaults and command bits
  // ****************************************************************
  localparam logic [CTRL_W-1:0] CTRL_DEF   = 8'h00;
  localparam logic [31:0]       RD_ZERO    = 32'h0000_0000;
  localparam int unsigned       CMD_SOFT_B = 0;
  // Revision value is arbitrary
  localparam logic [31:0]       REV_DEF    = 32'h0000_0101;
endpackage : mrc_pkg

// ---- rtl/mrc_store_if.sv ----
// Purpose: Port bundle between register decode and scratch storage
// Assumes: Single clock, one access per cycle
// Notes:   Read data appear the cycle after rd_en
`timescale 1ns/1ps
interface mrc_store_if;
  import mrc_pkg::*;
  logic              wr_en;
  logic              rd_en;
  logic [SCR_AW-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl  (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport store (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : mrc_store_if

// ---- rtl/mrc_store.sv ----
// Purpose: Uninitialised read/write scratch words with registered read
// Assumes: Caller never reads and writes the same word in one cycle
// Notes:   No reset on purpose; contents after power-up are arbitrary
`timescale 1ns/1ps
module mrc_store
  import mrc_pkg::*;
(
  input  wire logic ref_clk,
  mrc_store_if.store sif
);
  logic [DATA_W-1:0] mem_q [SCR_DEPTH];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge ref_clk) begin
    if (sif.wr_en) begin
      mem_q[sif.addr] <= sif.wdata;
    end
    if (sif.rd_en) begin
      rdata_q <= mem_q[sif.addr];
    end
  end

  assign sif.rdata = rdata_q;
endmodule : mrc_store

// ---- tb/mrc_core_model.sv ----
// Purpose: Processor core model issuing strobed register reads and writes
// Assumes: Each call starts right after a rising edge of ref_clk
// Notes:   Released address shows the inverse; data are inverted after writes only, reads leave them
`timescale 1ns/1ps
module mrc_core_model
  import mrc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [DATA_W-1:0] bus_rdata,
  output logic      [31:0]       bus_addr,
  output logic      [DATA_W-1:0] bus_wdata,
  output logic                   bus_wr,
  output logic                   bus_rd
);
  initial begin
    bus_addr  = 32'h0000_0000;
    bus_wdata = 32'h0000_0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // One idle cycle after each access, so a strobe never flips twice in a step
  task automatic wr(input logic [31:0] a, input logic [DATA_W-1:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [DATA_W-1:0] d);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    #1 d = bus_rdata;
    @(posedge ref_clk);
  endtask : rd

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [31:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    bus_rd    <= 1'b1;
    @(posedge ref_clk);
    bus_rd    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
    #1 q = bus_rdata;
    @(posedge ref_clk);
  endtask : wr_rd

  // Read-modify-write keeps bits outside the mask as found
  task automatic rmw(input logic [31:0] a, input logic [DATA_W-1:0] m, v);
    logic [DATA_W-1:0] cur;
    rd(a, cur);
    wr(a, (cur & ~m) | (v & m));
  endtask : rmw
endmodule : mrc_core_model

// ---- tb/mrc_regs_bench.sv ----
// Purpose: Self-checking bench for the register slice, unit index one
// Assumes: Defaults reload on hard and soft reset
// Notes:   Writes to unit zero must not reach this unit
`timescale 1ns/1ps
module mrc_regs_bench;
  import mrc_pkg::*;
  localparam logic [31:0] MMR  = 32'h0008_0000;
  localparam logic [31:0] MAP  = 32'h0000_0100;
  localparam logic [31:0] STR  = 32'h0000_0040;
  localparam logic [31:0] BASE = MMR + MAP + STR;
  localparam logic [31:0] PAT [4] = '{32'hFFFF_FFFF, 32'h8000_0001, 32'hA5A5_5A5A, 32'h0000_0000};
  logic              ref_clk;
  logic              rstn;
  logic [31:0]       bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic [DATA_W-1:0] live_status;
  logic [7:0]        evt_w1c;
  logic [7:0]        evt_rst;
  logic [7:0]        periph_en;
  logic [7:0]        irq_mask;
  logic [7:0]        cmd_pulse;
  logic              soft_reset;
  logic [7:0]        cmd_seen;
  logic [31:0]       rv;
  int                bad_count;
  int                checks_done;
  int                cmd_cnt;
  int                sr_cnt;

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  mrc_regs #(.MMR_BASE(MMR), .MAP_BASE(MAP), .INDEX_STRIDE(STR), .UNIT_INDEX(1),
    .N_EVT(8), .RESET_DEFAULTS(1'b1), .REV_VALUE(REV_DEF)) mrc_regs_inst (
    .ref_clk(ref_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .live_status(live_status),
    .evt_w1c(evt_w1c), .evt_rst(evt_rst), .periph_en(periph_en), .irq_mask(irq_mask),
    .cmd_pulse(cmd_pulse), .soft_reset(soft_reset));
  mrc_core_model mrc_core_model_inst (.ref_clk(ref_clk), .bus_rdata(bus_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));

  // Pulses are one cycle wide, so they are counted at every edge
  always @(posedge ref_clk) begin
    if (rstn === 1'b1 && cmd_pulse !== 8'h00) begin
      cmd_cnt++;
      cmd_seen = cmd_pulse;
    end
    if (soft_reset === 1'b1) sr_cnt++;
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [31:0] off, input logic [31:0] exp, input string what);
    mrc_core_model_inst.rd(BASE + off, rv);
    chk(what, rv, exp);
  endtask : rchk

  task automatic t_reset();
    rchk(OFF_REV, REV_DEF, "revision");
    chk("periph_en", {24'h0, periph_en}, {24'h0, CTRL_DEF});
    chk("irq_mask", {24'h0, irq_mask}, 32'h0000_0000);
    rchk(OFF_STK_W1C, 32'h0000_0000, "w1c sticky");
  endtask : t_reset

  task automatic t_readonly();
    live_status <= 32'h1234_5678;
    mrc_core_model_inst.wr(BASE + OFF_REV, 32'hFFFF_FFFF);
    mrc_core_model_inst.wr(BASE + OFF_STK_RST, 32'hFFFF_FFFF);
    mrc_core_model_inst.wr(BASE + OFF_LIVE, 32'h0000_0000);
    mrc_core_model_inst.wr(BASE + 32'h0000_0030, 32'hFFFF_FFFF);
    rchk(OFF_REV, REV_DEF, "revision after write");
    rchk(OFF_STK_RST, 32'h0000_0000, "reset sticky after write");
    rchk(OFF_LIVE, 32'h1234_5678, "live status");
    live_status <= 32'hC0DE_0042;
    rchk(OFF_LIVE, 32'hC0DE_0042, "live status changed");
    rchk(32'h0000_0030, 32'h0000_0000, "unmapped");
  endtask : t_readonly

  task automatic t_rw();
    mrc_core_model_inst.wr(BASE + OFF_CTRL, 32'h0000_005A);
    chk("periph_en", {24'h0, periph_en}, 32'h0000_005A);
    mrc_core_model_inst.wr(MMR + MAP + OFF_CTRL, 32'h0000_00FF);
    rchk(OFF_CTRL, 32'h0000_005A, "ctrl via other unit");
    mrc_core_model_inst.wr_rd(BASE + OFF_CTRL, 32'h0000_00C3, rv);
    chk("ctrl back to back", rv, 32'h0000_00C3);
    mrc_core_model_inst.rmw(BASE + OFF_IMASK, 32'h0000_000F, 32'h0000_0005);
    chk("irq_mask", {24'h0, irq_mask}, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      mrc_core_model_inst.wr(BASE + OFF_SCR + 32'(4 * i), PAT[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rchk(OFF_SCR + 32'(4 * i), PAT[i], "scratch word");
    end
  endtask : t_rw

  task automatic t_sticky();
    evt_w1c <= 8'h05;
    evt_rst <= 8'h81;
    @(posedge ref_clk);
    evt_w1c <= 8'h00;
    evt_rst <= 8'h00;
    @(posedge ref_clk);
    rchk(OFF_STK_W1C, 32'h0000_0005, "w1c sticky set");
    rchk(OFF_STK_RST, 32'h0000_0081, "reset sticky set");
    mrc_core_model_inst.wr(BASE + OFF_STK_W1C, 32'h0000_0004);
    rchk(OFF_STK_W1C, 32'h0000_0001, "w1c after clear");
    mrc_core_model_inst.wr(BASE + OFF_STK_W1C, 32'h0000_0000);
    rchk(OFF_STK_W1C, 32'h0000_0001, "w1c after zero");
    mrc_core_model_inst.wr(BASE + OFF_STK_RST, 32'h0000_00FF);
    rchk(OFF_STK_RST, 32'h0000_0081, "reset sticky after write");
  endtask : t_sticky

  task automatic t_cmd();
    mrc_core_model_inst.wr(BASE + OFF_CMD, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    chk("cmd pulses", 32'(cmd_cnt), 32'h0000_0001);
    chk("soft resets", 32'(sr_cnt), 32'h0000_0000);
    mrc_core_model_inst.wr(BASE + OFF_CMD, 32'h0000_00A5);
    repeat (2) @(posedge ref_clk);
    chk("cmd value", {24'h0, cmd_seen}, 32'h0000_00A5);
    chk("soft resets", 32'(sr_cnt), 32'h0000_0001);
    rchk(OFF_CTRL, {24'h0, CTRL_DEF}, "ctrl after soft reset");
    chk("irq_mask", {24'h0, irq_mask}, 32'h0000_0000);
    rchk(OFF_STK_RST, 32'h0000_0000, "reset sticky after soft reset");
    rchk(OFF_STK_W1C, 32'h0000_0001, "w1c after soft reset");
  endtask : t_cmd

  task automatic t_hard_reset();
    mrc_core_model_inst.wr(BASE + OFF_CTRL, 32'h0000_003C);
    mrc_core_model_inst.wr(BASE + OFF_IMASK, 32'h0000_00FF);
    evt_w1c <= 8'h20;
    evt_rst <= 8'h10;
    @(posedge ref_clk);
    evt_w1c <= 8'h00;
    evt_rst <= 8'h00;
    rchk(OFF_STK_RST, 32'h0000_0010, "reset sticky before hard reset");
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk("periph_en", {24'h0, periph_en}, {24'h0, CTRL_DEF});
    chk("irq_mask", {24'h0, irq_mask}, 32'h0000_0000);
    rchk(OFF_STK_RST, 32'h0000_0000, "reset sticky after hard reset");
    rchk(OFF_STK_W1C, 32'h0000_0000, "w1c after hard reset");
    rchk(OFF_CTRL, {24'h0, CTRL_DEF}, "ctrl after hard reset");
  endtask : t_hard_reset

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // A hang still ends in the report, counted as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    rstn        = 1'b0;
    live_status = 32'h0000_0000;
    evt_w1c     = 8'h00;
    evt_rst     = 8'h00;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_readonly();
    t_rw();
    t_sticky();
    t_cmd();
    t_hard_reset();
    complete_run();
  end
endmodule : mrc_regs_bench
